// >>> logic/ctsr_consts.svh
// Constants for the channel trim staging bank: offsets, fields, resets and timing.
// Assumes it is included by bare name from the package and the design modules.
`ifndef CTSR_CONSTS_SVH
`define CTSR_CONSTS_SVH

// ==========================================================================
// Bank geometry
`define CTSR_CH_NUM 4
`define CTSR_KIND_NUM 3
`define CTSR_TRIM_W 10
`define CTSR_ADDR_W 8
`define CTSR_DATA_W 16
`define CTSR_IN_W 10
`define CTSR_OUT_W 13

// ==========================================================================
// Register offsets
`define CTSR_ADDR_CAL_CTRL 8'h10
`define CTSR_ADDR_CAL_MBOX 8'h11
`define CTSR_ADDR_STG_OFFSET 8'h20
`define CTSR_ADDR_ACT_OFFSET 8'h21
`define CTSR_ADDR_STG_GAIN 8'h22
`define CTSR_ADDR_ACT_GAIN 8'h23
`define CTSR_ADDR_STG_PHASE 8'h24
`define CTSR_ADDR_ACT_PHASE 8'h25

// ==========================================================================
// Calibration control fields and mailbox
`define CTSR_FLD_OFFSET_LSB 6
`define CTSR_FLD_GAIN_LSB 4
`define CTSR_FLD_PHASE_LSB 2
`define CTSR_XFER_REQ 2'h2
`define CTSR_MBOX_BUSY_BIT 0

// ==========================================================================
// Trim kinds, as indices into the per-channel trim arrays
`define CTSR_KIND_OFFSET 2'h0
`define CTSR_KIND_GAIN 2'h1
`define CTSR_KIND_PHASE 2'h2

// ==========================================================================
// Reset values, lane codes and timing
`define CTSR_TRIM_RST 10'h200
`define CTSR_TRIM_ZERO_CODE 13'h0200
`define CTSR_GAIN_SHIFT 9
`define CTSR_LANE_A 3'h1
`define CTSR_LANE_B 3'h2
`define CTSR_LANE_C 3'h3
`define CTSR_LANE_D 3'h4
`define CTSR_XFER_CYCLES 4
`define CTSR_CNT_W 3

`endif

// >>> logic/ctsr_pkg.sv
// Types for the channel trim staging bank.
// Assumes ctsr_consts.svh is on the include path.
`include "ctsr_consts.svh"

package ctsr_pkg;

	// ======================================================================
	// Transfer sequencer state of one channel.
	typedef enum logic [1:0] {
		CTSR_IDLE,
		CTSR_GAIN,
		CTSR_OFFSET,
		CTSR_PHASE
	} ctsr_seq_t;

	typedef logic [`CTSR_TRIM_W-1:0] ctsr_trim_t;

	// ======================================================================
	// Whole state of the register bank.
	typedef struct packed {
		ctsr_trim_t [`CTSR_CH_NUM-1:0][`CTSR_KIND_NUM-1:0] staged;
		ctsr_trim_t [`CTSR_CH_NUM-1:0][`CTSR_KIND_NUM-1:0] active;
		logic [`CTSR_CH_NUM-1:0][5:0] calCtrl;
		logic [`CTSR_CH_NUM-1:0][`CTSR_KIND_NUM-1:0] pending;
		ctsr_seq_t [`CTSR_CH_NUM-1:0] seq;
		logic [`CTSR_CH_NUM-1:0][`CTSR_CNT_W-1:0] cnt;
		logic [`CTSR_DATA_W-1:0] readData;
		logic readValid;
	} ctsr_bank_t;

	// ======================================================================
	// State of one corrector.
	typedef struct packed {
		logic signed [`CTSR_OUT_W-1:0] sampleOut;
	} ctsr_corr_t;

endpackage

// >>> logic/ctsr_corrector.sv
// One channel corrector: output equals active offset plus input times active gain.
// Assumes the trims come from flops of the trim bank on the same clock.
`timescale 1ns/1ps
`include "ctsr_consts.svh"

module ctsr_corrector (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic signed [`CTSR_IN_W-1:0] sampleIn,
	input wire logic [`CTSR_TRIM_W-1:0] gainCode,
	input wire logic [`CTSR_TRIM_W-1:0] offsetCode,
	output logic signed [`CTSR_OUT_W-1:0] sampleOut
);

	ctsr_pkg::ctsr_corr_t cur;
	ctsr_pkg::ctsr_corr_t next_cur;
	logic signed [20:0] product;
	logic signed [`CTSR_OUT_W-1:0] scaled;
	logic signed [`CTSR_OUT_W-1:0] shift;

	// ======================================================================
	// Arithmetic
	// Gain code 0x200 is unity, so the product is scaled down by 512.
	// Offset code 0x000 is the largest positive shift and 0x3ff the largest negative.
	always_comb begin
		product = sampleIn * $signed({1'b0, gainCode});
		scaled = `CTSR_OUT_W'(product >>> `CTSR_GAIN_SHIFT);
		shift = $signed(`CTSR_TRIM_ZERO_CODE) - $signed({3'h0, offsetCode});
		next_cur = cur;
		next_cur.sampleOut = scaled + shift;
	end

	// ======================================================================
	// State register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign sampleOut = cur.sampleOut;

endmodule

// >>> logic/ctsr_trim_bank.sv
// Per-channel trim staging bank: staged and active offset, gain and phase trims,
// calibration control and mailbox, and the corrected sample outputs.
// Assumes the serial framing is decoded elsewhere on the same clock into
// one-cycle read and write strobes, and that the common lane selector register
// lives outside and is presented here as a level.
`timescale 1ns/1ps
`include "ctsr_consts.svh"

module ctsr_trim_bank #(
	parameter int XFER_CYCLES = `CTSR_XFER_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [2:0] lanePick,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [`CTSR_ADDR_W-1:0] regAddr,
	input wire logic [`CTSR_DATA_W-1:0] regWdata,
	output logic [`CTSR_DATA_W-1:0] regRdata,
	output logic regRvalid,
	output logic [`CTSR_CH_NUM-1:0] laneBusy,
	output logic [`CTSR_CH_NUM*`CTSR_TRIM_W-1:0] activePhase,
	input wire logic [`CTSR_CH_NUM*`CTSR_IN_W-1:0] sampleIn,
	output logic [`CTSR_CH_NUM*`CTSR_OUT_W-1:0] sampleOut
);

	// ======================================================================
	// Helper functions
	// Pure decoders, shared by the next-state logic, the read path and the outputs.

	// Turns a lane selector code into {valid, index}; unlisted codes are not valid.
	function automatic logic [2:0] decodeLane(input logic [2:0] code);
		logic [2:0] res;
		res = 3'h0;
		// Bit 2 flags a valid code; a caller must test it before trusting the index.
		case (code)
			`CTSR_LANE_A: res = 3'h4;
			`CTSR_LANE_B: res = 3'h5;
			`CTSR_LANE_C: res = 3'h6;
			`CTSR_LANE_D: res = 3'h7;
			default: res = 3'h0;
		endcase
		return res;
	endfunction

	// Picks the next transfer from a pending set, gain before offset before phase.
	function automatic ctsr_pkg::ctsr_seq_t pickNext(input logic [`CTSR_KIND_NUM-1:0] pend);
		ctsr_pkg::ctsr_seq_t res;
		res = ctsr_pkg::CTSR_IDLE;
		// An empty set gives idle, which is also how a chain of transfers ends.
		if (pend[`CTSR_KIND_GAIN]) begin
			res = ctsr_pkg::CTSR_GAIN;
		end else if (pend[`CTSR_KIND_OFFSET]) begin
			res = ctsr_pkg::CTSR_OFFSET;
		end else if (pend[`CTSR_KIND_PHASE]) begin
			res = ctsr_pkg::CTSR_PHASE;
		end
		return res;
	endfunction

	// True while a channel has a transfer queued or running. The mailbox bit and the
	// busy outputs share it, so the two can never disagree.
	function automatic logic chanBusy(input ctsr_pkg::ctsr_seq_t s,
		input logic [`CTSR_KIND_NUM-1:0] pend);
		return (s != ctsr_pkg::CTSR_IDLE) || (pend != '0);
	endfunction

	// Widens a trim to a bus word; the unused upper bits always read as zero.
	function automatic logic [`CTSR_DATA_W-1:0] trimWord(input ctsr_pkg::ctsr_trim_t t);
		return {6'h00, t};
	endfunction

	// Maps a running sequencer state to the trim kind it copies.
	// Only called for a running state; the offset default is never used for idle.
	function automatic logic [1:0] seqKind(input ctsr_pkg::ctsr_seq_t s);
		logic [1:0] res;
		res = `CTSR_KIND_OFFSET;
		case (s)
			ctsr_pkg::CTSR_GAIN: res = `CTSR_KIND_GAIN;
			ctsr_pkg::CTSR_PHASE: res = `CTSR_KIND_PHASE;
			default: res = `CTSR_KIND_OFFSET;
		endcase
		return res;
	endfunction

	// ======================================================================
	// State
	// A step loads XFER_CYCLES-1 and also spends the cycle in which the count reads
	// zero, so each step lasts XFER_CYCLES cycles; the counter must hold XFER_CYCLES-1.
	localparam logic [`CTSR_CNT_W-1:0] XFER_LAST = `CTSR_CNT_W'(XFER_CYCLES - 1);
	// The trim rows are filled by replication, so every channel and every kind gets
	// 0x200 whatever the packing of the two array dimensions.
	localparam ctsr_pkg::ctsr_bank_t BANK_RESET = '{
		staged: {(`CTSR_CH_NUM * `CTSR_KIND_NUM){`CTSR_TRIM_RST}},
		active: {(`CTSR_CH_NUM * `CTSR_KIND_NUM){`CTSR_TRIM_RST}},
		calCtrl: '0,
		pending: '0,
		seq: '{default: ctsr_pkg::CTSR_IDLE},
		cnt: '0,
		readData: '0,
		readValid: 1'b0
	};

	// The whole bank lives in one register; next_cur is its combinational copy.
	ctsr_pkg::ctsr_bank_t cur;
	ctsr_pkg::ctsr_bank_t next_cur;

	// ======================================================================
	// Next-state logic
	// The sequencer runs before the register write so that a request written in
	// the very cycle a transfer of the same kind completes is kept, not lost.
	always_comb begin
		logic [2:0] laneDec;
		logic laneOk;
		logic [1:0] lane;
		logic [1:0] kind;
		logic [`CTSR_KIND_NUM-1:0] rest;
		logic busy;
		laneDec = decodeLane(lanePick);
		laneOk = laneDec[2];
		lane = laneDec[1:0];
		kind = `CTSR_KIND_OFFSET;
		rest = '0;
		busy = 1'b0;
		next_cur = cur;
		next_cur.readValid = 1'b0;

		// Per-channel transfer sequencers; each step holds for XFER_CYCLES.
		// An idle channel spends one cycle picking its first step, so a lone transfer
		// keeps the channel busy for XFER_CYCLES plus one cycles.
		// The channels are independent; one busy channel never delays another.
		for (int ch = 0; ch < `CTSR_CH_NUM; ch++) begin
			case (cur.seq[ch])
				ctsr_pkg::CTSR_IDLE: begin
					// Orders are only queued by the write path; here they are started.
					if (cur.pending[ch] != '0) begin
						next_cur.seq[ch] = pickNext(cur.pending[ch]);
						next_cur.cnt[ch] = XFER_LAST;
					end
				end
				default: begin
					if (cur.cnt[ch] == '0) begin
						// The copy takes the staged value standing at this edge, so a
						// staged write made during the count still reaches the active trim.
						kind = seqKind(cur.seq[ch]);
						// Staged to active copy is the only path into active.
						next_cur.active[ch][kind] = cur.staged[ch][kind];
						rest = cur.pending[ch] & ~(`CTSR_KIND_NUM'(1) << kind);
						next_cur.pending[ch] = rest;
						// The next queued kind starts at once, with no idle cycle between.
						next_cur.seq[ch] = pickNext(rest);
						next_cur.cnt[ch] = XFER_LAST;
					end else begin
						// Zero always ends the step, so the count can never wrap.
						next_cur.cnt[ch] = cur.cnt[ch] - `CTSR_CNT_W'(1);
					end
				end
			endcase
		end

		// Register writes reach only the selected channel.
		// Without a valid code the lane index falls back to channel A, so the whole
		// write must be dropped rather than only guarded per register.
		if (regWrite && laneOk) begin
			case (regAddr)
				`CTSR_ADDR_CAL_CTRL: begin
					// The stored field keeps its value after the transfer.
					// Pending bits set here win over a completion clear in the same cycle,
					// because the sequencer above has already written its result.
					next_cur.calCtrl[lane] = regWdata[7:2];
					if (regWdata[`CTSR_FLD_OFFSET_LSB +: 2] == `CTSR_XFER_REQ) begin
						next_cur.pending[lane][`CTSR_KIND_OFFSET] = 1'b1;
					end
					if (regWdata[`CTSR_FLD_GAIN_LSB +: 2] == `CTSR_XFER_REQ) begin
						next_cur.pending[lane][`CTSR_KIND_GAIN] = 1'b1;
					end
					if (regWdata[`CTSR_FLD_PHASE_LSB +: 2] == `CTSR_XFER_REQ) begin
						next_cur.pending[lane][`CTSR_KIND_PHASE] = 1'b1;
					end
				end
				`CTSR_ADDR_STG_OFFSET: begin
					next_cur.staged[lane][`CTSR_KIND_OFFSET] = regWdata[9:0];
				end
				`CTSR_ADDR_STG_GAIN: begin
					next_cur.staged[lane][`CTSR_KIND_GAIN] = regWdata[9:0];
				end
				`CTSR_ADDR_STG_PHASE: begin
					next_cur.staged[lane][`CTSR_KIND_PHASE] = regWdata[9:0];
				end
				default: begin
					// Active trims, mailbox and unmapped offsets ignore writes.
				end
			endcase
		end

		// Register reads answer one cycle later; unused bits read zero.
		// Reads look at the state before this edge, so a read and a write in the same
		// cycle return the old value. A read with no channel chosen still answers, with
		// zero, so a host never waits on an answer that cannot come.
		if (regRead) begin
			next_cur.readValid = 1'b1;
			next_cur.readData = '0;
			busy = chanBusy(cur.seq[lane], cur.pending[lane]);
			if (laneOk) begin
				case (regAddr)
					`CTSR_ADDR_CAL_CTRL: begin
						next_cur.readData = {8'h00, cur.calCtrl[lane], 2'h0};
					end
					`CTSR_ADDR_CAL_MBOX: begin
						next_cur.readData[`CTSR_MBOX_BUSY_BIT] = busy;
					end
					`CTSR_ADDR_STG_OFFSET: begin
						next_cur.readData = trimWord(cur.staged[lane][`CTSR_KIND_OFFSET]);
					end
					`CTSR_ADDR_ACT_OFFSET: begin
						next_cur.readData = trimWord(cur.active[lane][`CTSR_KIND_OFFSET]);
					end
					`CTSR_ADDR_STG_GAIN: begin
						next_cur.readData = trimWord(cur.staged[lane][`CTSR_KIND_GAIN]);
					end
					`CTSR_ADDR_ACT_GAIN: begin
						next_cur.readData = trimWord(cur.active[lane][`CTSR_KIND_GAIN]);
					end
					`CTSR_ADDR_STG_PHASE: begin
						next_cur.readData = trimWord(cur.staged[lane][`CTSR_KIND_PHASE]);
					end
					`CTSR_ADDR_ACT_PHASE: begin
						next_cur.readData = trimWord(cur.active[lane][`CTSR_KIND_PHASE]);
					end
					default: begin
						next_cur.readData = '0;
					end
				endcase
			end
		end
	end

	// ======================================================================
	// State register
	// All trims reset to code 0x200: zero offset, unity gain, zero delay shift.
	// Reset is synchronous, so every channel of the bank settles on the same edge.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cur <= BANK_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	// ======================================================================
	// Outputs and per-channel correctors
	// Read data stands until the next answer replaces it; the valid pulse marks the
	// one cycle in which it is new.
	assign regRdata = cur.readData;
	assign regRvalid = cur.readValid;

	// One corrector per channel; all four run every cycle, chosen or not.
	genvar gi;
	generate
		for (gi = 0; gi < `CTSR_CH_NUM; gi++) begin : gen_lane
			// Busy covers both queued and running transfers of the channel.
			assign laneBusy[gi] = chanBusy(cur.seq[gi], cur.pending[gi]);
			// The delay line sees only the active phase, never the staged one.
			assign activePhase[gi*`CTSR_TRIM_W +: `CTSR_TRIM_W] =
				cur.active[gi][`CTSR_KIND_PHASE];
			// The corrector reads the active trims straight from the flops, so a copy
			// reaches the samples one cycle after it lands; staged values never do.
			ctsr_corrector u_corr (
				.clock(clock),
				.rst_n(rst_n),
				.sampleIn(sampleIn[gi*`CTSR_IN_W +: `CTSR_IN_W]),
				.gainCode(cur.active[gi][`CTSR_KIND_GAIN]),
				.offsetCode(cur.active[gi][`CTSR_KIND_OFFSET]),
				.sampleOut(sampleOut[gi*`CTSR_OUT_W +: `CTSR_OUT_W])
			);
		end
	endgenerate

endmodule

// >>> verification/ctsr_trim_bank_props.sv
// Port checker for the trim staging bank.
// Assumes a bind to ctsr_trim_bank and a single clock domain.
`timescale 1ns/1ps

module ctsr_bank_props #(
	parameter int XFER_CYCLES = 4
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [2:0] lanePick,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic [15:0] regRdata,
	input wire logic regRvalid,
	input wire logic [3:0] laneBusy,
	input wire logic [39:0] activePhase
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	logic [5:0] runLen;

	// ==================================================================
	// Busy run length of channel A, judged when busy drops.
	always_ff @(posedge clock) begin
		if (!rst_n || !laneBusy[0]) begin
			runLen <= 6'h00;
		end else begin
			runLen <= runLen + 6'h01;
		end
	end

	// ==================================================================
	// Transfer order on channel A, and the first busy cycles it must cause.
	sequence orderGainA;
		regWrite && regAddr == 8'h10 && regWdata[5:4] == 2'h2 && lanePick == 3'h1;
	endsequence
	sequence busyTwoA;
		laneBusy[0] ##1 laneBusy[0];
	endsequence

	chk_read_answer: assert property (regRead |=> regRvalid)
		else $error("read strobe got no answer");
	chk_no_spurious: assert property (!regRead |=> !regRvalid)
		else $error("answer without a read");
	chk_upper_zero: assert property (regRvalid |-> regRdata[15:10] == 6'h00)
		else $error("unused read bits not zero");
	chk_nolane_zero: assert property (regRead && !(lanePick inside {[3'h1:3'h4]})
		|=> regRdata == 16'h0000) else $error("read with no channel not zero");
	chk_busy_start: assert property (orderGainA |=> busyTwoA)
		else $error("busy missing after transfer order");
	chk_busy_cause: assert property ($rose(laneBusy[0]) |->
		$past(regWrite && regAddr == 8'h10 && lanePick == 3'h1))
		else $error("busy rose without an order");
	chk_phase_hold: assert property ($changed(activePhase[9:0]) |-> $past(laneBusy[0]))
		else $error("active phase moved while idle");
	chk_busy_len: assert property ($fell(laneBusy[0]) |-> runLen > XFER_CYCLES
		&& (int'(runLen) - 1) % XFER_CYCLES == 0) else $error("busy run length wrong");
endmodule

bind ctsr_trim_bank ctsr_bank_props #(.XFER_CYCLES(XFER_CYCLES)) uProps (.clock(clock),
	.rst_n(rst_n), .lanePick(lanePick), .regWrite(regWrite), .regRead(regRead),
	.regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
	.laneBusy(laneBusy), .activePhase(activePhase));

// >>> verification/ctsr_host_model.sv
// Host side of the register port: lane select plus one-cycle strobes.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ps

module ctsr_host_model (
	input wire logic clock,
	output logic [2:0] lanePick,
	output logic regWrite,
	output logic regRead,
	output logic [7:0] regAddr,
	output logic [15:0] regWdata
);
	// ==================================================================
	// Idle bus at time zero.
	initial begin
		lanePick = 3'h0;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWdata = 16'h0000;
	end

	// ==================================================================
	// One access after an optional stall; the idle bus is scrambled so stale data never helps.
	task automatic acc(input int gap, input logic [2:0] ln, input logic wr,
		input logic [7:0] a, input logic [15:0] d);
		repeat (gap) @(posedge clock);
		@(posedge clock);
		#1;
		lanePick = ln;
		regWrite = wr;
		regRead = !wr;
		regAddr = a;
		regWdata = d;
		@(posedge clock);
		#1;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = ~a;
		regWdata = ~d;
	endtask

	// Order transfers by writing the control fields.
	task automatic order(input logic [2:0] ln, input logic [15:0] f);
		acc(0, ln, 1'b1, 8'h10, f);
	endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the trim staging bank.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps

module tb_top;
	logic clock;
	logic rst_n;
	logic [2:0] lanePick;
	logic regWrite;
	logic regRead;
	logic [7:0] regAddr;
	logic [15:0] regWdata;
	logic [15:0] regRdata;
	logic regRvalid;
	logic [3:0] laneBusy;
	logic [39:0] activePhase;
	logic [39:0] sampleIn;
	logic [51:0] sampleOut;
	logic [15:0] expQ[$];
	logic [9:0] stg[4][3];
	logic [9:0] act[4][3];
	int err_count;
	int n_tests;
	int noLane[4] = '{0, 5, 6, 7};
	int idleCode[3] = '{0, 1, 3};

	ctsr_trim_bank #(.XFER_CYCLES(4)) uut (.clock(clock), .rst_n(rst_n), .lanePick(lanePick),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
		.regRdata(regRdata), .regRvalid(regRvalid), .laneBusy(laneBusy),
		.activePhase(activePhase), .sampleIn(sampleIn), .sampleOut(sampleOut));
	ctsr_host_model host (.clock(clock), .lanePick(lanePick), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata));

	// ==================================================================
	// Clock and reporting.
	initial clock = 1'b0;
	always #10 clock = ~clock;

	task automatic cmp(input logic [15:0] got, input logic [15:0] e);
		n_tests++;
		if (got !== e) begin
			err_count++;
			$display("wrong value at %0t: read %h expected %h", $time, got, e);
		end
	endtask
	task automatic cmps(input logic [12:0] got, input logic [12:0] e);
		n_tests++;
		if (got !== e) begin
			err_count++;
			$display("wrong value at %0t: sample %h expected %h", $time, got, e);
		end
	endtask
	task automatic wrap_up();
		$display("mismatches %0d of %0d checks", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Read answers are matched, oldest first, against the notes left by rd.
	always @(negedge clock) begin
		if (regRvalid === 1'b1) begin
			cmp(regRdata, (expQ.size() > 0) ? expQ.pop_front() : ~regRdata);
		end
	end

	// ==================================================================
	// Access helpers and the reference for the corrected samples.
	task automatic rd(input int g, input int ln, input logic [7:0] a, input logic [15:0] e);
		expQ.push_back(e);
		host.acc(g, 3'(ln), 1'b0, a, 16'h0000);
	endtask
	function automatic logic [12:0] expOut(input logic [9:0] x, input logic [9:0] g,
		input logic [9:0] o);
		int p;
		p = $signed(x) * int'(g);
		return 13'((p >>> 9) + 512 - int'(o));
	endfunction
	task automatic rstDev();
		rst_n = 1'b0;
		foreach (stg[l, k]) begin
			stg[l][k] = 10'h200;
			act[l][k] = 10'h200;
		end
		repeat (8) @(posedge clock);
		#1;
		rst_n = 1'b1;
	endtask
	task automatic waitIdle();
		int i;
		for (i = 0; i < 60 && laneBusy !== 4'h0; i++) @(posedge clock);
		if (i == 60) begin
			err_count++;
			$display("wrong value at %0t: busy never cleared", $time);
			wrap_up();
		end
	endtask

	// ==================================================================
	// Main sequence.
	initial begin
		logic [15:0] v;
		rst_n = 1'b0;
		sampleIn = '0;
		err_count = 0;
		n_tests = 0;
		void'($urandom(79));
		rstDev();
		for (int l = 1; l < 5; l++) begin
			for (int a = 16; a < 38; a++) begin
				if (a < 18 || a > 31) rd(0, l, 8'(a), (a > 17) ? 16'h0200 : 16'h0000);
			end
		end
		foreach (stg[l, k]) begin
			v = 16'($urandom);
			host.acc(0, 3'(l + 1), 1'b1, 8'h20 + 8'(2 * k), v);
			host.acc(0, 3'(l + 1), 1'b1, 8'h21 + 8'(2 * k), ~v);
			stg[l][k] = v[9:0];
		end
		foreach (stg[l, k]) rd(0, l + 1, 8'h20 + 8'(2 * k), {6'h00, stg[l][k]});
		foreach (stg[l, k]) rd(0, l + 1, 8'h21 + 8'(2 * k), {6'h00, act[l][k]});
		foreach (noLane[b]) begin
			host.acc(0, 3'(noLane[b]), 1'b1, 8'h20, 16'h0155);
			rd(0, noLane[b], 8'h20, 16'h0000);
		end
		rd(0, 1, 8'h20, {6'h00, stg[0][0]});
		foreach (idleCode[c]) begin
			v = {8'h00, 2'(idleCode[c]), 2'(idleCode[c]), 2'(idleCode[c]), 2'h0};
			host.order(3'h1, v);
			cmp({12'h000, laneBusy}, 16'h0000);
			rd(0, 1, 8'h10, v);
		end
		rd(0, 1, 8'h21, 16'h0200);
		host.order(3'h1, 16'h00a8);
		rd(4, 1, 8'h23, {6'h00, stg[0][1]});
		rd(0, 1, 8'h21, 16'h0200);
		rd(0, 1, 8'h11, 16'h0001);
		waitIdle();
		act[0] = stg[0];
		for (int k = 0; k < 3; k++) rd(0, 1, 8'h21 + 8'(2 * k), {6'h00, act[0][k]});
		rd(0, 1, 8'h10, 16'h00a8);
		rd(0, 2, 8'h23, 16'h0200);
		cmps({3'h0, activePhase[9:0]}, {3'h0, stg[0][2]});
		for (int l = 0; l < 4; l++) begin
			v = 16'($urandom);
			sampleIn[l * 10 +: 10] = v[9:0];
			repeat (2) @(posedge clock);
			#1;
			cmps(sampleOut[l * 13 +: 13], expOut(v[9:0], act[l][1], act[l][0]));
		end
		rstDev();
		rd(0, 1, 8'h23, 16'h0200);
		rd(0, 1, 8'h24, 16'h0200);
		repeat (4) @(posedge clock);
		if (expQ.size() != 0) begin
			err_count++;
			$display("wrong value at %0t: read answers missing", $time);
		end
		wrap_up();
	end
endmodule
